// file: rtl/tbd_deadtime.sv
`timescale 1ns/10ps
// one complementary pair with rising edges delayed by the dead count
module tbd_deadtime (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // control
  input wire logic i_tick,
  input wire logic [tbd_pkg::TBD_DT_W-1:0] i_dead,
  input wire logic i_ref,
  // outputs
  output logic o_true,
  output logic o_comp
);
  import tbd_pkg::*;
  logic ref_q;
  logic [TBD_DT_W-1:0] cnt_q;

  // restart count on every reference edge, release after dead ticks
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_q <= 1'b0;
      cnt_q <= '0;
      o_true <= 1'b0;
      o_comp <= 1'b0;
    end else begin
      ref_q <= i_ref;
      if (i_ref != ref_q) begin
        cnt_q <= i_dead;
        o_true <= 1'b0; // RULE23
        o_comp <= 1'b0;
      end else if (cnt_q != '0) begin
        if (i_tick) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end else begin
        o_true <= i_ref; // RULE23
        o_comp <= ~i_ref;
      end
    end
  end
endmodule

// file: rtl/tbd_pkg.sv
// Contract
// RULE1 - break clears main gate asynchronously
// RULE2 - main gate off disables or idles outputs
// RULE3 - auto gate sets main gate on update
// RULE4 - polarity bit selects active break level
// RULE5 - polarity and gate writes delayed one cycle
// RULE6 - break gate enables pin and clock failure
// RULE7 - run off-state selects inactive drive
// RULE8 - idle off-state selects inactive drive
// RULE9 - level 01 protects code, gates, idle levels
// RULE10 - level 10 adds polarities, off-states
// RULE11 - level 11 adds compare mode, preload
// RULE12 - lock level writable once after reset
// RULE13 - software programs all fields first write
// RULE14 - code 0xx: code times period
// RULE15 - code 10x: (64+low6) times two periods
// RULE16 - code 110: (32+low5) times eight periods
// RULE17 - code 111: (32+low5) times sixteen periods
// RULE18 - period from clock divide field
// RULE19 - burst count is length field plus one; the code stops at 18 accesses for length fields above 17
// RULE20 - base index selects first register
// RULE21 - each next access four bytes higher
// RULE22 - start address is base index times four
// RULE23 - delay rising edges by dead count
// RULE24 - protected writes ignored, reads unchanged
package tbd_pkg;
  localparam logic [7:0] TBD_OFF_BKDT = 8'h44;
  localparam logic [7:0] TBD_OFF_DCTRL = 8'h48;
  localparam logic [7:0] TBD_OFF_CTRL = 8'h50;
  localparam logic [15:0] TBD_BKDT_RST = 16'h0000;
  localparam logic [15:0] TBD_DCTRL_RST = 16'h0000;
  localparam logic [15:0] TBD_CTRL_RST = 16'h0000;
  localparam int TBD_B_MAIN = 15;
  localparam int TBD_B_AUTO = 14;
  localparam int TBD_B_BPOL = 13;
  localparam int TBD_B_BGATE = 12;
  localparam int TBD_B_RUNOFF = 11;
  localparam int TBD_B_IDLEOFF = 10;
  localparam int TBD_B_LOCK = 8;
  localparam logic [15:0] TBD_M_LOCK1 = 16'h70FF;
  localparam logic [15:0] TBD_M_LOCK2 = 16'h7CFF;
  localparam logic [15:0] TBD_M_DCTRL = 16'h1F1F;
  localparam logic [1:0] TBD_LK_NONE = 2'h0;
  localparam logic [1:0] TBD_LK_L1 = 2'h1;
  localparam logic [1:0] TBD_LK_L2 = 2'h2;
  localparam logic [7:0] TBD_DT_BASE64 = 8'h40;
  localparam logic [7:0] TBD_DT_BASE32 = 8'h20;
  localparam int TBD_DT_W = 12;
  localparam logic [4:0] TBD_LEN_MAX = 5'h11;
  localparam logic [7:0] TBD_BURST_STEP = 8'h04;
endpackage

// file: rtl/tbd_top.sv
`timescale 1ns/10ps
module tbd_top #(
  parameter int CHANNELS = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // break sources and update event
  input wire logic i_break_pin,
  input wire logic i_clock_failure_detector,
  input wire logic i_update_event,
  // channel settings from the timer
  input wire logic [CHANNELS-1:0] i_channel_output_enable,
  input wire logic [CHANNELS-1:0] i_complementary_output_enable,
  input wire logic [CHANNELS-1:0] i_output_idle_level,
  input wire logic [CHANNELS-1:0] i_complementary_idle_level,
  input wire logic [CHANNELS-1:0] i_oc_ref,
  input wire logic [1:0] i_dead_time_clock_divide,
  // dma window access
  input wire logic i_burst_access,
  input wire logic i_burst_restart,
  // write permissions for protected fields elsewhere
  output logic o_idle_level_write_ok,
  output logic o_polarity_write_ok,
  output logic o_compare_write_ok,
  // burst mapping
  output logic [7:0] o_burst_addr,
  output logic o_burst_last,
  // output stage
  output logic [CHANNELS-1:0] o_true,
  output logic [CHANNELS-1:0] o_true_en,
  output logic [CHANNELS-1:0] o_comp,
  output logic [CHANNELS-1:0] o_comp_en,
  output logic o_main_output_gate
);
  import tbd_pkg::*;

  logic [15:0] bkdt_q;
  logic [15:0] dctrl_q;
  logic [15:0] ctrl_q;
  logic lock_written_q;
  logic break_polarity_q;
  logic break_gate_q;
  logic main_gate_q;
  logic [4:0] burst_cnt_q;
  logic [1:0] div_cnt_q;
  logic [1:0] div_q;
  logic dt_tick;
  logic break_raw;
  logic break_active;
  logic wr_en;
  logic rd_en;
  logic [15:0] wmask;
  logic [15:0] bkdt_d;
  logic [TBD_DT_W-1:0] dead_count;
  logic [CHANNELS-1:0] gen_true;
  logic [CHANNELS-1:0] gen_comp;
  logic [7:0] code;
  logic [1:0] lock_level;
  logic burst_end;
  logic [7:0] burst_word;

  assign lock_level = bkdt_q[TBD_B_LOCK +: 2];
  assign code = bkdt_q[7:0];
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;

  // writable mask per lock level
  always_comb begin
    case (lock_level)
      TBD_LK_NONE: wmask = 16'hFFFF;
      TBD_LK_L1: wmask = ~TBD_M_LOCK1; // RULE9
      TBD_LK_L2: wmask = ~TBD_M_LOCK2; // RULE10
      default: wmask = ~TBD_M_LOCK2; // RULE11
    endcase
    if (lock_written_q) begin
      wmask[TBD_B_LOCK +: 2] = 2'h0; // RULE12
    end
    wmask[TBD_B_MAIN] = 1'b0;
    bkdt_d = (bkdt_q & ~wmask) | (i_pwdata[15:0] & wmask); // RULE24
  end

  // break register storage, main gate bit kept apart
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bkdt_q <= TBD_BKDT_RST;
      lock_written_q <= 1'b0;
    end else if (wr_en && i_paddr == TBD_OFF_BKDT) begin
      bkdt_q <= bkdt_d;
      lock_written_q <= 1'b1; // RULE12
    end
  end

  // dma control register also sets burst base and length; control register stored and read back only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dctrl_q <= TBD_DCTRL_RST;
      ctrl_q <= TBD_CTRL_RST;
    end else if (wr_en) begin
      if (i_paddr == TBD_OFF_DCTRL) begin
        dctrl_q <= i_pwdata[15:0] & TBD_M_DCTRL;
      end
      if (i_paddr == TBD_OFF_CTRL) begin
        ctrl_q <= i_pwdata[15:0];
      end
    end
  end

  // polarity and gate copies lag the register by one cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      break_polarity_q <= 1'b0;
      break_gate_q <= 1'b0;
    end else begin
      break_polarity_q <= bkdt_q[TBD_B_BPOL]; // RULE5
      break_gate_q <= bkdt_q[TBD_B_BGATE]; // RULE5
    end
  end

  // break detection
  assign break_raw = (i_break_pin == break_polarity_q) || i_clock_failure_detector; // RULE4
  assign break_active = break_gate_q && break_raw; // RULE6

  // main gate, cleared by break without waiting for the clock
  always_ff @(posedge i_clk or negedge i_reset_n or posedge break_active) begin
    if (!i_reset_n) begin
      main_gate_q <= 1'b0;
    end else if (break_active) begin
      main_gate_q <= 1'b0; // RULE1
    end else if (wr_en && i_paddr == TBD_OFF_BKDT) begin
      main_gate_q <= i_pwdata[TBD_B_MAIN];
    end else if (bkdt_q[TBD_B_AUTO] && i_update_event) begin
      main_gate_q <= 1'b1; // RULE3
    end
  end

  // apb read and answer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (rd_en) begin
        case (i_paddr)
          TBD_OFF_BKDT: o_prdata <= {16'h0000, main_gate_q, bkdt_q[14:0]}; // RULE24
          TBD_OFF_DCTRL: o_prdata <= {16'h0000, dctrl_q};
          TBD_OFF_CTRL: o_prdata <= {16'h0000, ctrl_q};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // dead-time clock from divide field: 1, 2 or 4 system clocks
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q <= 2'h0;
      div_cnt_q <= 2'h0;
    end else begin
      div_q <= i_dead_time_clock_divide; // RULE18
      if (dt_tick) begin
        div_cnt_q <= 2'h0;
      end else begin
        div_cnt_q <= div_cnt_q + 2'h1;
      end
    end
  end
  assign dt_tick = (div_q == 2'h0) || (div_q == 2'h1 && div_cnt_q == 2'h1) ||
                   (div_q[1] && div_cnt_q == 2'h3); // RULE18

  // dead code decode into ticks
  always_comb begin
    if (!code[7]) begin
      dead_count = {4'h0, code}; // RULE14
    end else if (!code[6]) begin
      dead_count = TBD_DT_W'({TBD_DT_BASE64 + {2'b00, code[5:0]}, 1'b0}); // RULE15
    end else if (!code[5]) begin
      dead_count = TBD_DT_W'({TBD_DT_BASE32 + {3'b000, code[4:0]}, 3'b000}); // RULE16
    end else begin
      dead_count = TBD_DT_W'({TBD_DT_BASE32 + {3'b000, code[4:0]}, 4'h0}); // RULE17
    end
  end

  // one dead-time pair per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_pair
      tbd_deadtime u_dt (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_tick(dt_tick),
        .i_dead(dead_count),
        .i_ref(i_oc_ref[g]),
        .o_true(gen_true[g]),
        .o_comp(gen_comp[g])
      );
    end
  endgenerate

  // output gating for run and idle states
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_true <= '0;
      o_true_en <= '0;
      o_comp <= '0;
      o_comp_en <= '0;
    end else if (main_gate_q) begin
      o_true <= gen_true & i_channel_output_enable; // RULE2
      o_comp <= gen_comp & i_complementary_output_enable;
      o_true_en <= bkdt_q[TBD_B_RUNOFF] ? i_channel_output_enable : // RULE7
                   i_channel_output_enable & gen_true;
      o_comp_en <= bkdt_q[TBD_B_RUNOFF] ? i_complementary_output_enable :
                   i_complementary_output_enable & gen_comp;
    end else begin
      o_true <= i_output_idle_level; // RULE2
      o_comp <= i_complementary_idle_level;
      o_true_en <= bkdt_q[TBD_B_IDLEOFF] ? i_channel_output_enable : '0; // RULE8
      o_comp_en <= bkdt_q[TBD_B_IDLEOFF] ? i_complementary_output_enable : '0;
    end
  end

  // last access of the burst from the live count, word index of the next access
  assign burst_end = (burst_cnt_q >= dctrl_q[12:8]) || (burst_cnt_q >= TBD_LEN_MAX); // RULE19
  assign burst_word = {3'b000, dctrl_q[4:0]} + {3'b000, burst_cnt_q}; // RULE20 RULE22

  // burst sequencing over the window register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      burst_cnt_q <= 5'h00;
    end else if (i_burst_restart || (i_burst_access && burst_end)) begin
      burst_cnt_q <= 5'h00;
    end else if (i_burst_access) begin
      burst_cnt_q <= burst_cnt_q + 5'h01; // RULE21
    end
  end

  // mapped address and permissions registered for the outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_burst_addr <= 8'h00;
      o_burst_last <= 1'b0;
      o_idle_level_write_ok <= 1'b1;
      o_polarity_write_ok <= 1'b1;
      o_compare_write_ok <= 1'b1;
      o_main_output_gate <= 1'b0;
    end else begin
      o_burst_addr <= {burst_word[5:0], 2'b00}; // RULE20 RULE22
      o_burst_last <= burst_end; // RULE19
      o_idle_level_write_ok <= (lock_level == TBD_LK_NONE); // RULE9
      o_polarity_write_ok <= !lock_level[1]; // RULE10
      o_compare_write_ok <= (lock_level != 2'h3); // RULE11
      o_main_output_gate <= main_gate_q;
    end
  end
endmodule

// file: verif/tb_timer_break_deadtime_dma_burst.sv
`timescale 1ns/10ps
module tb_timer_break_deadtime_dma_burst;
  import tbd_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0, bp = 0, cfd = 0, upd = 0, go = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [3:0] ref_w = 4'h0, il = 4'h0, cil = 4'h0, gap = 4'h0, tr, tre, cp, cpe;
  logic [1:0] div = 2'h0;
  logic [4:0] plen = 5'h00;
  logic [2:0] wok;
  logic [7:0] baddr;
  logic acc, rs, done, pready, gate, acc_q, rs_q, acc_q2, rs_q2, last, slverr;
  int err_count = 0, compares = 0, cyc = 0, seed = 48874, base, len, n, e;
  int q[$];
  logic [7:0] codes[4] = '{8'h05, 8'h83, 8'hC1, 8'hE0};
  // device under test and dma partner
  tbd_top u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready),
    .o_pslverr(slverr), .i_break_pin(bp), .i_clock_failure_detector(cfd), .i_update_event(upd),
    .i_channel_output_enable(4'h7), .i_complementary_output_enable(4'h7),
    .i_output_idle_level(il), .i_complementary_idle_level(cil), .i_oc_ref(ref_w),
    .i_dead_time_clock_divide(div), .i_burst_access(acc), .i_burst_restart(rs),
    .o_idle_level_write_ok(wok[0]), .o_polarity_write_ok(wok[1]),
    .o_compare_write_ok(wok[2]), .o_burst_addr(baddr), .o_burst_last(last), .o_true(tr),
    .o_true_en(tre), .o_comp(cp), .o_comp_en(cpe), .o_main_output_gate(gate));
  tbd_dma_model u_dma (.i_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_len(plen),
    .i_gap(gap), .o_burst_access(acc), .o_burst_restart(rs), .o_done(done));
  always #12.5 clk = ~clk;
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1; pen <= 0; pw <= w; pa <= a; pwd <= d;
    @(posedge clk); pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prd; psel <= 0; pen <= 0;
    chk("pslverr", 0, slverr);
  endtask
  task rst_cycle;
    rst_n <= 0; repeat (8) @(posedge clk); rst_n <= 1;
  endtask
  function automatic int dtn(logic [7:0] c);
    if (!c[7]) return c;
    if (!c[6]) return (64 + c[5:0]) * 2;
    if (!c[5]) return (32 + c[4:0]) * 8;
    return (32 + c[4:0]) * 16;
  endfunction
  // model of the window mapping, checked two edges after each restart and after each access but the last of a burst
  always @(posedge clk) begin
    acc_q <= acc; rs_q <= rs; acc_q2 <= acc_q; rs_q2 <= rs_q;
    if ((acc_q2 || rs_q2) && q.size() > 0) begin
      chk("burst_addr", 32'(q.pop_front()), baddr);
      chk("burst_last", 32'(q.size() == 0), last);
    end
    cyc++;
    if (cyc == 40000) begin err_count++; give_verdict; end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1; il <= 4'($random(seed)); cil <= 4'($random(seed));
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(8'h44 + i * 4), 0); chk("reset_val", 0, rd);
    end
    for (int i = 0; i < 4; i++) begin
      div <= 2'(i / 3);
      apb(1, 8'h44, 32'h8000 | codes[i]);
      e = dtn(codes[i]) * (i / 3 + 1);
      ref_w[0] <= 0; repeat (e + 8) @(posedge clk);
      ref_w[0] <= 1; n = 0;
      do begin @(posedge clk); n++; end while (tr[0] !== 1'b1 && n < 3000);
      chk("dead_time", 1, n >= e && n <= e + 4);
    end
    cfd <= 1; repeat (3) @(posedge clk); chk("gate", 1, gate);
    cfd <= 0;
    apb(1, 8'h44, 32'hF000); repeat (3) @(posedge clk); chk("gate", 1, gate);
    bp <= 1; repeat (3) @(posedge clk); chk("gate", 0, gate);
    chk("true_en", 0, tre);
    chk("comp_en", 0, cpe);
    chk("idle_true", il, tr);
    chk("idle_comp", cil, cp);
    upd <= 1; @(posedge clk); upd <= 0; repeat (2) @(posedge clk); chk("gate", 0, gate);
    apb(0, 8'h44, 0); chk("bkdt", 32'h7000, rd);
    bp <= 0; upd <= 1; @(posedge clk); upd <= 0;
    repeat (3) @(posedge clk); chk("gate", 1, gate);
    chk("true_en", 4'h1, tre);
    chk("comp_en", 4'h6, cpe);
    apb(1, 8'h44, 32'hF800); repeat (2) @(posedge clk);
    chk("true_en", 4'h7, tre);
    chk("comp_en", 4'h7, cpe);
    for (int r = 0; r < 2; r++) begin
      base = $random(seed) & 15; len = $random(seed) & 15;
      apb(1, 8'h48, ($random(seed) & 32'hFFFF_E0E0) | (len << 8) | base);
      apb(0, 8'h48, 0); chk("dctrl", (len << 8) | base, rd);
      for (int k = 0; k <= len; k++) q.push_back((base + k) * 4);
      plen <= 5'(len); gap <= 4'(r * 2); go <= 1; @(posedge clk); go <= 0;
      n = 0;
      do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 300);
      repeat (3) @(posedge clk);
      chk("burst_left", 0, q.size());
    end
    rst_cycle;
    apb(1, 8'h44, 32'h0123);
    apb(1, 8'h44, 32'h0F99); apb(0, 8'h44, 0);
    chk("bkdt", 32'h0D23, rd);
    chk("write_ok", 3'b110, wok);
    rst_cycle;
    apb(1, 8'h44, 32'h0200); apb(1, 8'h44, 32'h7FFF); apb(0, 8'h44, 0);
    chk("bkdt", 32'h0200, rd);
    chk("write_ok", 3'b100, wok);
    rst_cycle;
    apb(1, 8'h44, 32'h0300); repeat (2) @(posedge clk);
    chk("write_ok", 3'b000, wok);
    give_verdict;
  end
endmodule
bind tbd_top tbd_monitor #(.CHANNELS(CHANNELS)) u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
  .i_burst_access(i_burst_access), .i_burst_restart(i_burst_restart),
  .o_burst_last(o_burst_last), .o_burst_addr(o_burst_addr),
  .i_channel_output_enable(i_channel_output_enable),
  .i_complementary_output_enable(i_complementary_output_enable), .o_true(o_true),
  .o_true_en(o_true_en), .o_comp(o_comp), .o_main_output_gate(o_main_output_gate),
  .o_idle_level_write_ok(o_idle_level_write_ok), .o_polarity_write_ok(o_polarity_write_ok),
  .o_compare_write_ok(o_compare_write_ok));

// file: verif/tbd_dma_model.sv
`timescale 1ns/10ps
module tbd_dma_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // burst request
  input wire logic i_go,
  input wire logic [4:0] i_len,
  input wire logic [3:0] i_gap,
  // window accesses
  output logic o_burst_access,
  output logic o_burst_restart,
  output logic o_done
);
  int n;
  int g;
  // restart then length plus one accesses, gap idle cycles between
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_burst_access <= 1'b0;
      o_burst_restart <= 1'b0;
      o_done <= 1'b0;
      n <= -1;
      g <= 0;
    end else begin
      o_burst_access <= 1'b0;
      o_burst_restart <= 1'b0;
      o_done <= 1'b0;
      if (i_go) begin
        o_burst_restart <= 1'b1;
        n <= i_len + 1;
        g <= i_gap;
      end else if (n > 0) begin
        if (g > 0) begin
          g <= g - 1;
        end else begin
          o_burst_access <= 1'b1;
          n <= n - 1;
          g <= i_gap;
        end
      end else if (n == 0) begin
        o_done <= 1'b1;
        n <= -1;
      end
    end
  end
endmodule

// file: verif/tbd_monitor.sv
`timescale 1ns/10ps
module tbd_monitor #(
  parameter int CHANNELS = 4
) (
  // watched ports
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic i_burst_access,
  input wire logic i_burst_restart,
  input wire logic o_burst_last,
  input wire logic [7:0] o_burst_addr,
  input wire logic [CHANNELS-1:0] i_channel_output_enable,
  input wire logic [CHANNELS-1:0] i_complementary_output_enable,
  input wire logic [CHANNELS-1:0] o_true,
  input wire logic [CHANNELS-1:0] o_true_en,
  input wire logic [CHANNELS-1:0] o_comp,
  input wire logic o_main_output_gate,
  input wire logic o_idle_level_write_ok,
  input wire logic o_polarity_write_ok,
  input wire logic o_compare_write_ok
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // burst window walks up one word per access
  property p_burst_step;
    i_burst_access && !i_burst_restart && !i_psel ##1 !o_burst_last
      |=> o_burst_addr == $past(o_burst_addr) + 8'h04;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst step wrong");
  property p_burst_hold;
    !i_burst_access && !i_burst_restart && !i_psel ##1
      !i_burst_access && !i_burst_restart && !i_psel |=> $stable(o_burst_addr);
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst addr moved");
  // pair never both high while driven
  property p_no_overlap;
    o_main_output_gate |-> (o_true & o_comp) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("outputs overlap");
  property p_lock_sticky;
    !o_idle_level_write_ok |=> !o_idle_level_write_ok;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock released");
  property p_lock_nest;
    !o_compare_write_ok |-> !o_polarity_write_ok;
  endproperty
  a_lock_nest: assert property (p_lock_nest) else $error("level 3 not nested");
  property p_lock_l1;
    !o_polarity_write_ok |-> !o_idle_level_write_ok;
  endproperty
  a_lock_l1: assert property (p_lock_l1) else $error("level 2 not nested");
  property p_en_cause;
    (o_true_en & ~$past(i_channel_output_enable | i_complementary_output_enable)) == '0;
  endproperty
  a_en_cause: assert property (p_en_cause) else $error("enable without channel");
  property p_pready;
    i_psel && !i_penable |=> o_pready ##1 !o_pready;
  endproperty
  a_pready: assert property (p_pready) else $error("apb answer late");
endmodule
